// ---- sdh_ctrl_regs.vh ----
// Register indices, field positions and reset values of the control block
`ifndef SDH_CTRL_REGS_VH
`define SDH_CTRL_REGS_VH

// Register indices; byte address is four times the index
`define SDH_IDX_MONO_RSIDE     8'h39
`define SDH_IDX_LSIDE          8'h3A
`define SDH_IDX_IN_SERVO       8'h3C
`define SDH_IDX_HP_SERVO       8'h3D
`define SDH_IDX_STEPS          8'h40
`define SDH_IDX_INIT_STATUS    8'h42
`define SDH_IDX_PGA_BIAS       8'h44
`define SDH_IDX_STAGES         8'h45
`define SDH_IDX_IRQ_STATUS     8'h50
`define SDH_IDX_IRQ_MASK       8'h51

// Sidetone mixing fields
`define SDH_BIT_MONO           9
`define SDH_GAIN_HI            7
`define SDH_GAIN_LO            4
`define SDH_SRC_HI             3
`define SDH_SRC_LO             2
`define SDH_SRC_NONE0          2'h0
`define SDH_SRC_LEFT_ADC       2'h1
`define SDH_SRC_RIGHT_ADC      2'h2
`define SDH_GAIN_UNITY_MSB     2'h3
`define SDH_GAIN_STEPS_MAX     4'hC

// Servo control fields, left at the upper nibble, right at the lower
`define SDH_BIT_L_ON           7
`define SDH_BIT_L_INIT         6
`define SDH_BIT_L_SERIES       4
`define SDH_BIT_R_ON           3
`define SDH_BIT_R_INIT         2
`define SDH_BIT_R_SERIES       0

// Series step count field
`define SDH_STEPS_HI           13
`define SDH_STEPS_LO           7
`define SDH_STEPS_RESET        7'h10
`define SDH_STEPS_MIN          7'h10

// Start-up completion flags
`define SDH_BIT_DONE_IN_L      10
`define SDH_BIT_DONE_IN_R      9
`define SDH_BIT_DONE_HP_L      8
`define SDH_BIT_DONE_HP_R      7

// Amplifier bias register
`define SDH_BIAS_RSV_HI        4
`define SDH_BIAS_RSV_LO        3
`define SDH_BIAS_RSV_RESET     2'h3
`define SDH_BIAS_HI            2
`define SDH_BIAS_RESET         3'h3

// Headphone stage enables
`define SDH_STAGES_RESET       8'h00

// Interrupt events
`define SDH_IRQ_WIDTH          6
`define SDH_IRQ_RESET          6'h00

`endif

// ---- sdh_sidetone_gain.v ----
// Sidetone attenuator: -36 dB to -3 dB in 3 dB steps, unity above
`timescale 1ns/100ps
`include "sdh_ctrl_regs.vh"

module sdh_sidetone_gain #(
  parameter AW = 16
) (
  // Sample and gain code
  input  wire signed [AW-1:0] i_sample,
  input  wire        [3:0]    i_code,
  // Attenuated sample
  output wire signed [AW-1:0] o_sample
);

  wire        [3:0]    steps;
  wire        [2:0]    shift;
  wire signed [AW-1:0] shifted;
  wire signed [AW+8:0] odd_prod;

  // Twelve steps at code zero, one fewer per code
  assign steps    = `SDH_GAIN_STEPS_MAX - i_code;
  assign shift    = steps[3:1];
  assign shifted  = i_sample >>> shift;
  // Odd step scales by 181/256, about 3.01 dB more cut; cheaper than a full table
  assign odd_prod = shifted * $signed({1'b0, 8'hB5});
  assign o_sample = (i_code[3:2] == `SDH_GAIN_UNITY_MSB) ? i_sample :
                    steps[0] ? odd_prod[AW+7:8] : shifted;

endmodule

// ---- sdh_servo_engine.v ----
// One DC servo path: start-up correction and counted series of updates
`timescale 1ns/100ps
`include "sdh_ctrl_regs.vh"

module sdh_servo_engine #(
  parameter INIT_CYCLES   = 256,
  parameter UPDATE_CYCLES = 16
) (
  // Clock and reset
  input  wire       i_clock,
  input  wire       i_sys_rst,
  // Control
  input  wire       i_on,
  input  wire       i_init,
  input  wire       i_series,
  input  wire [6:0] i_steps,
  // Status
  output reg        o_init_done,
  output reg        o_update,
  output reg        o_init_end,
  output reg        o_series_end,
  output wire       o_busy
);

  localparam ST_IDLE   = 2'b00;
  localparam ST_INIT   = 2'b01;
  localparam ST_SERIES = 2'b10;

  reg [1:0]  state;
  reg [15:0] timer;
  reg [6:0]  left;

  assign o_busy = (state != ST_IDLE);

  // Sequencer; a new trigger restarts whatever was running
  always @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state        <= ST_IDLE;
      timer        <= 16'h0000;
      left         <= 7'h00;
      o_init_done  <= 1'b0;
      o_update     <= 1'b0;
      o_init_end   <= 1'b0;
      o_series_end <= 1'b0;
    end else begin
      o_update     <= 1'b0;
      o_init_end   <= 1'b0;
      o_series_end <= 1'b0;
      if (!i_on) begin
        state       <= ST_IDLE;
        o_init_done <= 1'b0;
      end else if (i_init) begin
        state       <= ST_INIT;
        timer       <= INIT_CYCLES[15:0];
        o_init_done <= 1'b0;
      end else if (i_series) begin
        state <= ST_SERIES;
        timer <= UPDATE_CYCLES[15:0];
        left  <= (i_steps < `SDH_STEPS_MIN) ? `SDH_STEPS_MIN : i_steps;
      end else begin
        case (state)
          ST_INIT: begin
            if (timer == 16'h0001) begin
              state       <= ST_IDLE;
              o_init_done <= 1'b1;
              o_init_end  <= 1'b1;
            end
            timer <= timer - 16'h0001;
          end
          ST_SERIES: begin
            if (timer == 16'h0001) begin
              o_update <= 1'b1;
              timer    <= UPDATE_CYCLES[15:0];
              left     <= left - 7'h01;
              if (left == 7'h01) begin
                state        <= ST_IDLE;
                o_series_end <= 1'b1;
              end
            end else begin
              timer <= timer - 16'h0001;
            end
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

endmodule

// ---- sdh_ctrl.v ----
// Sidetone, DC servo and headphone stage control with Wishbone registers
//
// Contract
// - Mono mix sums both channels onto the enabled DAC; clear keeps stereo. Code puts it on both DACs, ignoring the enables.
// - The mono sum is attenuated by a fixed 6 dB.
// - Sidetone gain runs -36 dB at 0 in 3 dB steps, and 11xx gives 0 dB.
// - Sidetone source 01 is left ADC, 10 right ADC, 00 and 11 none.
// - Four servo enable bits, one per input path and headphone output.
// - Writing 1 to a start-up trigger runs start-up correction there.
// - Writing 1 to a series trigger runs a series of headphone updates.
// - A shared 7-bit count sets series length, resets to 16, below 16 reserved.
// - Four read-only flags show completed start-up correction per path.
// - Amplifier bias field: 000 double, 011 nominal and reset, rest reserved.
// - An output stays shorted while its unclamp bit is 0, set last.
`timescale 1ns/100ps
`include "sdh_ctrl_regs.vh"

module sdh_ctrl #(
  parameter AW            = 16,
  parameter INIT_CYCLES   = 256,
  parameter UPDATE_CYCLES = 16
) (
  // Clock and reset
  input  wire                 i_clock,
  input  wire                 i_sys_rst,
  // Wishbone classic slave
  input  wire                 i_wb_cyc,
  input  wire                 i_wb_stb,
  input  wire                 i_wb_we,
  input  wire [9:0]           i_wb_adr,
  input  wire [3:0]           i_wb_sel,
  input  wire [31:0]          i_wb_dat,
  output reg  [31:0]          o_wb_dat,
  output reg                  o_wb_ack,
  // Audio samples, same clock domain
  input  wire                 i_sample_valid,
  input  wire signed [AW-1:0] i_dac_left,
  input  wire signed [AW-1:0] i_dac_right,
  input  wire signed [AW-1:0] i_adc_left,
  input  wire signed [AW-1:0] i_adc_right,
  input  wire                 i_dac_left_on,
  input  wire                 i_dac_right_on,
  output reg  signed [AW-1:0] o_dac_left,
  output reg  signed [AW-1:0] o_dac_right,
  output reg                  o_dac_valid,
  // DC servo controls to the analogue paths
  output wire [3:0]           o_servo_on,
  output wire [3:0]           o_servo_busy,
  output wire [1:0]           o_phone_servo_update,
  // Headphone stages and bias
  output wire                 o_left_phone_first_stage_on,
  output wire                 o_left_phone_middle_stage_on,
  output wire                 o_left_phone_final_stage_on,
  output wire                 o_left_phone_unclamp,
  output wire                 o_right_phone_first_stage_on,
  output wire                 o_right_phone_middle_stage_on,
  output wire                 o_right_phone_final_stage_on,
  output wire                 o_right_phone_unclamp,
  output wire [2:0]           o_phone_amp_bias_select,
  // Interrupt
  output wire                 o_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Saturating add and sidetone source pick, each used for both channels

  function signed [AW-1:0] sat_add;
    input signed [AW-1:0] a;
    input signed [AW-1:0] b;
    reg   signed [AW:0]   s;
    begin
      s = {a[AW-1], a} + {b[AW-1], b};
      if (s[AW] != s[AW-1])
        sat_add = s[AW] ? {1'b1, {(AW-1){1'b0}}} : {1'b0, {(AW-1){1'b1}}};
      else
        sat_add = s[AW-1:0];
    end
  endfunction

  function signed [AW-1:0] src_pick;
    input        [1:0]    sel;
    input signed [AW-1:0] adc_l;
    input signed [AW-1:0] adc_r;
    begin
      case (sel)
        `SDH_SRC_LEFT_ADC:  src_pick = adc_l;
        `SDH_SRC_RIGHT_ADC: src_pick = adc_r;
        default:            src_pick = {AW{1'b0}};
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register state

  reg        dac_single_channel_sum;
  reg [3:0]  right_sidetone_gain;
  reg [1:0]  right_sidetone_source;
  reg [3:0]  left_sidetone_gain;
  reg [1:0]  left_sidetone_source;
  reg [3:0]  servo_on;
  reg [6:0]  servo_series_count;
  reg [1:0]  bias_reserved;
  reg [2:0]  phone_amp_bias_select;
  reg [7:0]  stage_enables;
  reg [`SDH_IRQ_WIDTH-1:0] irq_status;
  reg [`SDH_IRQ_WIDTH-1:0] irq_mask;
  reg [3:0]  init_pulse;
  reg [1:0]  series_pulse;

  wire [7:0] idx;
  wire       req;
  wire       wr;
  wire       lo_en;
  wire       hi_en;
  wire [15:0] wd;
  wire [3:0] init_done;
  wire [3:0] init_end;
  wire [1:0] series_end;
  wire [3:0] eng_update;
  wire [3:0] eng_series_end;
  wire [`SDH_IRQ_WIDTH-1:0] irq_events;
  reg  [15:0] next_rdata;

  // Index is the word address; only the low 16 bits carry data
  assign idx   = i_wb_adr[9:2];
  assign req   = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  assign wr    = req & i_wb_we;
  assign lo_en = i_wb_sel[0];
  assign hi_en = i_wb_sel[1];
  assign wd    = i_wb_dat[15:0];

  ////////////////////////////////////////////////////////////////////////////
  // Bus answer: one wait state, ack drops the cycle after it rose

  always @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h00000000;
    end else begin
      o_wb_ack <= req;
      o_wb_dat <= {16'h0000, next_rdata};
    end
  end

  // Read mux; unmapped indices read zero, triggers always read zero
  always @* begin
    next_rdata = 16'h0000;
    case (idx)
      `SDH_IDX_MONO_RSIDE: begin
        next_rdata[`SDH_BIT_MONO]              = dac_single_channel_sum;
        next_rdata[`SDH_GAIN_HI:`SDH_GAIN_LO]  = right_sidetone_gain;
        next_rdata[`SDH_SRC_HI:`SDH_SRC_LO]    = right_sidetone_source;
      end
      `SDH_IDX_LSIDE: begin
        next_rdata[`SDH_GAIN_HI:`SDH_GAIN_LO]  = left_sidetone_gain;
        next_rdata[`SDH_SRC_HI:`SDH_SRC_LO]    = left_sidetone_source;
      end
      `SDH_IDX_IN_SERVO: begin
        next_rdata[`SDH_BIT_L_ON] = servo_on[3];
        next_rdata[`SDH_BIT_R_ON] = servo_on[2];
      end
      `SDH_IDX_HP_SERVO: begin
        next_rdata[`SDH_BIT_L_ON] = servo_on[1];
        next_rdata[`SDH_BIT_R_ON] = servo_on[0];
      end
      `SDH_IDX_STEPS:
        next_rdata[`SDH_STEPS_HI:`SDH_STEPS_LO] = servo_series_count;
      `SDH_IDX_INIT_STATUS: begin
        next_rdata[`SDH_BIT_DONE_IN_L] = init_done[3];
        next_rdata[`SDH_BIT_DONE_IN_R] = init_done[2];
        next_rdata[`SDH_BIT_DONE_HP_L] = init_done[1];
        next_rdata[`SDH_BIT_DONE_HP_R] = init_done[0];
      end
      `SDH_IDX_PGA_BIAS: begin
        next_rdata[`SDH_BIAS_RSV_HI:`SDH_BIAS_RSV_LO] = bias_reserved;
        next_rdata[`SDH_BIAS_HI:0] = phone_amp_bias_select;
      end
      `SDH_IDX_STAGES:     next_rdata[7:0] = stage_enables;
      `SDH_IDX_IRQ_STATUS: next_rdata[`SDH_IRQ_WIDTH-1:0] = irq_status;
      `SDH_IDX_IRQ_MASK:   next_rdata[`SDH_IRQ_WIDTH-1:0] = irq_mask;
      default:             next_rdata = 16'h0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes; take effect at the edge where ack rises

  always @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      dac_single_channel_sum <= 1'b0;
      right_sidetone_gain    <= 4'h0;
      right_sidetone_source  <= 2'h0;
      left_sidetone_gain     <= 4'h0;
      left_sidetone_source   <= 2'h0;
      servo_on               <= 4'h0;
      servo_series_count     <= `SDH_STEPS_RESET;
      bias_reserved          <= `SDH_BIAS_RSV_RESET;
      phone_amp_bias_select  <= `SDH_BIAS_RESET;
      stage_enables          <= `SDH_STAGES_RESET;
      irq_mask               <= `SDH_IRQ_RESET;
      init_pulse             <= 4'h0;
      series_pulse           <= 2'h0;
    end else begin
      // Triggers live for one cycle only and are never stored
      init_pulse   <= 4'h0;
      series_pulse <= 2'h0;
      if (wr && lo_en) begin
        case (idx)
          `SDH_IDX_MONO_RSIDE: begin
            right_sidetone_gain   <= wd[`SDH_GAIN_HI:`SDH_GAIN_LO];
            right_sidetone_source <= wd[`SDH_SRC_HI:`SDH_SRC_LO];
          end
          `SDH_IDX_LSIDE: begin
            left_sidetone_gain   <= wd[`SDH_GAIN_HI:`SDH_GAIN_LO];
            left_sidetone_source <= wd[`SDH_SRC_HI:`SDH_SRC_LO];
          end
          `SDH_IDX_IN_SERVO: begin
            servo_on[3]   <= wd[`SDH_BIT_L_ON];
            servo_on[2]   <= wd[`SDH_BIT_R_ON];
            init_pulse[3] <= wd[`SDH_BIT_L_INIT];
            init_pulse[2] <= wd[`SDH_BIT_R_INIT];
          end
          `SDH_IDX_HP_SERVO: begin
            servo_on[1]     <= wd[`SDH_BIT_L_ON];
            servo_on[0]     <= wd[`SDH_BIT_R_ON];
            init_pulse[1]   <= wd[`SDH_BIT_L_INIT];
            init_pulse[0]   <= wd[`SDH_BIT_R_INIT];
            series_pulse[1] <= wd[`SDH_BIT_L_SERIES];
            series_pulse[0] <= wd[`SDH_BIT_R_SERIES];
          end
          `SDH_IDX_PGA_BIAS: begin
            bias_reserved <= wd[`SDH_BIAS_RSV_HI:`SDH_BIAS_RSV_LO];
            phone_amp_bias_select <= wd[`SDH_BIAS_HI:0];
          end
          `SDH_IDX_STAGES: stage_enables <= wd[7:0];
          `SDH_IDX_IRQ_MASK: irq_mask <= wd[`SDH_IRQ_WIDTH-1:0];
          default: ;
        endcase
      end
      // Upper byte holds the mono bit and the top six bits of the step count
      if (wr && hi_en) begin
        case (idx)
          `SDH_IDX_MONO_RSIDE:
            dac_single_channel_sum <= wd[`SDH_BIT_MONO];
          `SDH_IDX_STEPS: begin
            servo_series_count[6] <= wd[`SDH_STEPS_HI];
          end
          default: ;
        endcase
      end
      // Step field straddles both byte lanes
      if (wr && lo_en && idx == `SDH_IDX_STEPS)
        servo_series_count[0] <= wd[`SDH_STEPS_LO];
      if (wr && hi_en && idx == `SDH_IDX_STEPS)
        servo_series_count[5:1] <= wd[`SDH_STEPS_HI-1:`SDH_STEPS_LO+1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status: events set, write-one clears, set wins

  assign irq_events = {series_end, init_end};

  always @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      irq_status <= `SDH_IRQ_RESET;
    end else begin
      if (wr && lo_en && idx == `SDH_IDX_IRQ_STATUS)
        irq_status <= (irq_status & ~wd[`SDH_IRQ_WIDTH-1:0]) | irq_events;
      else
        irq_status <= irq_status | irq_events;
    end
  end

  assign o_irq = |(irq_status & irq_mask);

  ////////////////////////////////////////////////////////////////////////////
  // DC servo engines: input left, input right, phone left, phone right

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : servo
      sdh_servo_engine #(
        .INIT_CYCLES   (INIT_CYCLES),
        .UPDATE_CYCLES (UPDATE_CYCLES)
      ) u_engine (
        .i_clock      (i_clock),
        .i_sys_rst    (i_sys_rst),
        .i_on         (servo_on[g]),
        .i_init       (init_pulse[g]),
        .i_series     ((g < 2) ? series_pulse[g % 2] : 1'b0),
        .i_steps      (servo_series_count),
        .o_init_done  (init_done[g]),
        .o_update     (eng_update[g]),
        .o_init_end   (init_end[g]),
        .o_series_end (eng_series_end[g]),
        .o_busy       (o_servo_busy[g])
      );
    end
  endgenerate

  // Series end and update pulses of the two phone engines
  assign series_end           = eng_series_end[1:0];
  assign o_phone_servo_update = eng_update[1:0];
  assign o_servo_on = servo_on;

  ////////////////////////////////////////////////////////////////////////////
  // Headphone stages; the ordering of writes is left to software

  assign o_left_phone_unclamp          = stage_enables[7];
  assign o_left_phone_final_stage_on   = stage_enables[6];
  assign o_left_phone_middle_stage_on  = stage_enables[5];
  assign o_left_phone_first_stage_on   = stage_enables[4];
  assign o_right_phone_unclamp         = stage_enables[3];
  assign o_right_phone_final_stage_on  = stage_enables[2];
  assign o_right_phone_middle_stage_on = stage_enables[1];
  assign o_right_phone_first_stage_on  = stage_enables[0];
  assign o_phone_amp_bias_select       = phone_amp_bias_select;

  ////////////////////////////////////////////////////////////////////////////
  // Sidetone and mono mix datapath

  wire signed [AW-1:0] left_side_raw;
  wire signed [AW-1:0] right_side_raw;
  wire signed [AW-1:0] left_side;
  wire signed [AW-1:0] right_side;
  wire signed [AW:0]   mono_sum;
  wire signed [AW-1:0] mono;
  wire signed [AW-1:0] main_left;
  wire signed [AW-1:0] main_right;

  assign left_side_raw  = src_pick(left_sidetone_source, i_adc_left,
                                   i_adc_right);
  assign right_side_raw = src_pick(right_sidetone_source, i_adc_left,
                                   i_adc_right);

  sdh_sidetone_gain #(.AW(AW)) u_left_gain (
    .i_sample (left_side_raw),
    .i_code   (left_sidetone_gain),
    .o_sample (left_side)
  );

  sdh_sidetone_gain #(.AW(AW)) u_right_gain (
    .i_sample (right_side_raw),
    .i_code   (right_sidetone_gain),
    .o_sample (right_side)
  );

  // Halving the sum is the 6 dB cut and also rules out overflow
  assign mono_sum   = {i_dac_left[AW-1], i_dac_left} +
                      {i_dac_right[AW-1], i_dac_right};
  assign mono       = mono_sum[AW:1];
  // Both outputs carry the mix; only the enabled DAC is listening
  assign main_left  = dac_single_channel_sum ? mono : i_dac_left;
  assign main_right = dac_single_channel_sum ? mono : i_dac_right;

  // Output samples are registered once per valid strobe
  always @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_dac_left  <= {AW{1'b0}};
      o_dac_right <= {AW{1'b0}};
      o_dac_valid <= 1'b0;
    end else begin
      o_dac_valid <= i_sample_valid;
      if (i_sample_valid) begin
        o_dac_left  <= sat_add(main_left, left_side);
        o_dac_right <= sat_add(main_right, right_side);
      end
    end
  end

endmodule

// ---- sdh_ctrl_properties.sv ----
// Port-level assertions for the sidetone and servo control block
`timescale 1ns/100ps
`include "sdh_ctrl_regs.vh"
module sdh_ctrl_properties (
  // Clock, reset and bus
  input wire        i_clock,
  input wire        i_sys_rst,
  input wire        i_wb_cyc,
  input wire        i_wb_stb,
  input wire        i_wb_we,
  input wire [9:0]  i_wb_adr,
  input wire [3:0]  i_wb_sel,
  input wire [31:0] i_wb_dat,
  input wire [31:0] o_wb_dat,
  input wire        o_wb_ack,
  // Audio strobes and control outputs
  input wire        i_sample_valid,
  input wire        o_dac_valid,
  input wire [3:0]  o_servo_on,
  input wire [1:0]  o_phone_servo_update,
  input wire        o_left_phone_unclamp,
  input wire        o_right_phone_unclamp,
  input wire [2:0]  o_phone_amp_bias_select
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  // Low-byte write taken at this edge; its fields land by the next
  wire       wr = i_wb_cyc & i_wb_stb & i_wb_we & ~o_wb_ack & i_wb_sel[0];
  wire [7:0] ix = i_wb_adr[9:2];
  ////////////////////////////////////////////////////////////////////////
  ack_one_wait_a: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack
    |=> o_wb_ack) else $error("ack not one cycle after request");
  ack_pulse_a: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack held two cycles");
  trig_read_zero_a: assert property (o_wb_ack && !$past(i_wb_we) &&
    $past(ix) == `SDH_IDX_HP_SERVO |-> (o_wb_dat & 32'h55) == 0)
    else $error("trigger bit read back as one");
  in_servo_on_a: assert property (wr && ix == `SDH_IDX_IN_SERVO
    |=> o_servo_on[3:2] == $past({i_wb_dat[7], i_wb_dat[3]}))
    else $error("input servo enables wrong");
  hp_servo_on_a: assert property (wr && ix == `SDH_IDX_HP_SERVO
    |=> o_servo_on[1:0] == $past({i_wb_dat[7], i_wb_dat[3]}))
    else $error("phone servo enables wrong");
  unclamp_out_a: assert property (wr && ix == `SDH_IDX_STAGES |=>
    {o_left_phone_unclamp, o_right_phone_unclamp} ==
    $past({i_wb_dat[7], i_wb_dat[3]})) else $error("unclamp wrong");
  bias_out_a: assert property (wr && ix == `SDH_IDX_PGA_BIAS
    |=> o_phone_amp_bias_select == $past(i_wb_dat[2:0]))
    else $error("bias select wrong");
  update_pulse_a: assert property (o_phone_servo_update[0]
    |=> !o_phone_servo_update[0]) else $error("update pulse too long");
  dac_valid_a: assert property (i_sample_valid |=> o_dac_valid)
    else $error("mixed sample late");
endmodule
bind sdh_ctrl sdh_ctrl_properties chk (.i_clock(i_clock),
  .i_sys_rst(i_sys_rst), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
  .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel),
  .i_wb_dat(i_wb_dat), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
  .i_sample_valid(i_sample_valid), .o_dac_valid(o_dac_valid),
  .o_servo_on(o_servo_on), .o_phone_servo_update(o_phone_servo_update),
  .o_left_phone_unclamp(o_left_phone_unclamp),
  .o_right_phone_unclamp(o_right_phone_unclamp),
  .o_phone_amp_bias_select(o_phone_amp_bias_select));

// ---- sidetone_dcservo_hp_ctrl_regs_tb.sv ----
// Self-checking bench for the sidetone and servo control block
`timescale 1ns/100ps
`include "sdh_ctrl_regs.vh"
module sidetone_dcservo_hp_ctrl_regs_tb;
  reg                i_clock, i_sys_rst, cyc, stb, we, sv;
  reg         [9:0]  adr;
  reg         [31:0] wdat;
  reg  signed [15:0] dl, dr, al, ar;
  reg         [15:0] q;
  wire        [31:0] rdat;
  wire               ack, dvalid, irq;
  wire signed [15:0] outl, outr;
  wire        [3:0]  son, busy;
  wire        [1:0]  upd;
  wire        [7:0]  stg;
  wire        [2:0]  bias;
  integer            bad_count = 0, checks_done = 0, pulses = 0, p0, i;
  // Short servo counts keep the run brief
  sdh_ctrl #(.INIT_CYCLES(4), .UPDATE_CYCLES(2)) uut (.i_clock(i_clock),
    .i_sys_rst(i_sys_rst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(wdat), .o_wb_dat(rdat),
    .o_wb_ack(ack), .i_sample_valid(sv), .i_dac_left(dl),
    .i_dac_right(dr), .i_adc_left(al), .i_adc_right(ar),
    .i_dac_left_on(1'b1), .i_dac_right_on(1'b0), .o_dac_left(outl),
    .o_dac_right(outr), .o_dac_valid(dvalid), .o_servo_on(son),
    .o_servo_busy(busy), .o_phone_servo_update(upd),
    .o_left_phone_unclamp(stg[7]), .o_left_phone_final_stage_on(stg[6]),
    .o_left_phone_middle_stage_on(stg[5]),
    .o_left_phone_first_stage_on(stg[4]),
    .o_right_phone_unclamp(stg[3]), .o_right_phone_final_stage_on(stg[2]),
    .o_right_phone_middle_stage_on(stg[1]),
    .o_right_phone_first_stage_on(stg[0]),
    .o_phone_amp_bias_select(bias), .o_irq(irq));
  // Clock at 250 MHz
  initial begin
    i_clock = 1'b0;
    forever #2 i_clock = ~i_clock;
  end
  // Right phone update pulses, counted per series
  always @(posedge i_clock) if (upd[0]) pulses <= pulses + 1;
  ////////////////////////////////////////////////////////////////////////
  task check(input [15:0] seen, input [15:0] exp);
    checks_done = checks_done + 1;
    if (seen !== exp) begin
      bad_count = bad_count + 1;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // One classic cycle; ends off the edge so outputs have settled
  task wb(input w, input [7:0] ix, input [15:0] d);
    integer n;
    n = 0;
    @(posedge i_clock);
    {cyc, stb, we} <= {2'b11, w};
    adr <= {ix, 2'b00};
    wdat <= {16'h0000, d};
    do begin
      @(posedge i_clock);
      n = n + 1;
    end while (ack !== 1'b1 && n < 20);
    q = rdat[15:0];
    {cyc, stb} <= 2'b00;
    @(negedge i_clock);
    if (n == 20) begin
      bad_count = bad_count + 1;
      give_verdict;
    end
  endtask
  task wait_irq;
    integer k;
    for (k = 0; k < 200 && irq !== 1'b1; k = k + 1) @(posedge i_clock);
    check(irq, 1);
    if (irq !== 1'b1) give_verdict;
  endtask
  task sample(input [15:0] a, b, c, e);
    @(posedge i_clock);
    {sv, dl, dr, al, ar} <= {1'b1, a, b, c, e};
    @(posedge i_clock);
    sv <= 1'b0;
    @(negedge i_clock);
    check(dvalid, 1);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task t_reset_values;
    check({son, stg, bias}, 15'h0003);
    wb(0, `SDH_IDX_STEPS, 0);
    check(q, 16'h0800);
    wb(0, `SDH_IDX_PGA_BIAS, 0);
    check(q, 16'h001B);
    wb(0, 8'h60, 16'hFFFF);
    check(q, 16'h0000);
  endtask
  task t_registers;
    wb(1, `SDH_IDX_STAGES, 16'h0011);
    check(stg, 8'h11);
    // 20 us before the middle stages
    repeat (5000) @(posedge i_clock);
    wb(1, `SDH_IDX_STAGES, 16'h0033);
    check(stg, 8'h33);
    wb(1, `SDH_IDX_PGA_BIAS, 16'h0018);
    check(bias, 3'h0);
  endtask
  // Start-up on all four paths, then disable one and see its done flag clear
  task t_startup;
    wb(1, `SDH_IDX_IRQ_MASK, 16'h003F);
    wb(1, `SDH_IDX_IN_SERVO, 16'h00CC);
    wb(1, `SDH_IDX_HP_SERVO, 16'h00CC);
    check(son, 4'hF);
    wb(0, `SDH_IDX_HP_SERVO, 0);
    check(q, 16'h0088);
    wait_irq;
    repeat (8) @(posedge i_clock);
    wb(0, `SDH_IDX_INIT_STATUS, 0);
    check(q, 16'h0780);
    // Offsets cancelled: output stages, then unclamp last
    wb(1, `SDH_IDX_STAGES, 16'h0077);
    check(stg, 8'h77);
    wb(1, `SDH_IDX_STAGES, 16'h00FF);
    check(stg, 8'hFF);
    wb(1, `SDH_IDX_IRQ_STATUS, 16'h000F);
    check(irq, 0);
    wb(1, `SDH_IDX_HP_SERVO, 16'h0008);
    wb(0, `SDH_IDX_INIT_STATUS, 0);
    check(q, 16'h0680);
  endtask
  // Step count 17 runs as is; reserved 5 runs as 16
  task t_series;
    for (i = 0; i < 2; i = i + 1) begin
      wb(1, `SDH_IDX_STEPS, i ? 16'h0280 : 16'h0880);
      p0 = pulses;
      wb(1, `SDH_IDX_HP_SERVO, 16'h0009);
      check(busy, 4'h1);
      wait_irq;
      check(pulses - p0, i ? 16 : 17);
      check(busy, 4'h0);
      wb(1, `SDH_IDX_IRQ_MASK, 16'h0000);
      check(irq, 0);
      wb(1, `SDH_IDX_IRQ_MASK, 16'h003F);
      wb(1, `SDH_IDX_IRQ_STATUS, 16'h0010);
      check(irq, 0);
    end
  endtask
  // Every sidetone source at 0 dB, then mono sum with -36 dB sidetone
  task t_audio;
    wb(1, `SDH_IDX_MONO_RSIDE, 16'h0000);
    for (i = 0; i < 4; i = i + 1) begin
      wb(1, `SDH_IDX_LSIDE, 16'h00C0 | (i << 2));
      sample(100, -7, 3, 50);
      check(outl, 100 + (i == 1 ? 3 : i == 2 ? 50 : 0));
    end
    check(outr, -7);
    wb(1, `SDH_IDX_MONO_RSIDE, 16'h0204);
    sample(100, -20, 640, 50);
    check(outl, 40);
    check(outr, 50);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {cyc, stb, we, sv} = 4'h0;
    {adr, wdat, dl, dr, al, ar} = 0;
    i_sys_rst = 1'b1;
    repeat (6) @(posedge i_clock);
    i_sys_rst <= 1'b0;
    @(negedge i_clock);
    t_reset_values;
    t_registers;
    t_startup;
    t_series;
    t_audio;
    give_verdict;
  end
endmodule
